// file: rtl/pfs_seq.sv
/*
 program flow sequencer: pc, fetch, jumps, call/return, interrupt entry,
 code table reads, external-move redirection to code flash.
 assumes code memory answers a read in the same cycle (combinational
 code_data_in), stack ram read combinationally and written at the clock edge at stack_addr_out,
 bit value for the conditional branch supplied by the core alongside.
*/
// Function
// - table read loads code byte at acc+data_pointer, or at acc+next address
// - select bit sends external writes to flash unless flash protect set
// - select bit also lets writes erase page
// - program counter clears to zero at reset
// - fetch sequentially until flow change
// - bit-set jump branches only when bit one
// - branch target is next address plus displacement
// - long jump loads full target address
// - short jump uses signed next-relative displacement
// - in-block jump replaces low eleven bits
// - long jump and bit jump three bytes, other jumps two
// - long call pushes pc then jumps
// - return reloads pc popped from stack
// - interrupt diverts to handler, resumes after
// - stack pointer resets to 07, pre-increment push
// - pop reads then decrements stack pointer
`timescale 1ns/1ps
`include "pfs_map.svh"
module pfs_seq (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // code memory
   output logic [15:0] code_addr_out,
   input wire logic [7:0] code_data_in,
   // core state
   input wire logic [7:0] acc_in,
   input wire logic [15:0] data_pointer_in,
   input wire logic test_bit_in,
   input wire logic code_flash_write_select_in,
   input wire logic flash_protect_in,
   input wire logic page_erase_in,
   // interrupt
   input wire logic irq_req_in,
   input wire logic [15:0] irq_vector_in,
   output logic irq_ack_out,
   // stack ram
   output logic [7:0] stack_addr_out,
   output logic [7:0] stack_wdata_out,
   output logic stack_we_out,
   input wire logic [7:0] stack_rdata_in,
   // results
   output logic [15:0] pc_out,
   output logic [7:0] opcode_out,
   output logic acc_load_out,
   output logic [7:0] acc_data_out,
   output logic flash_write_out,
   output logic flash_erase_out,
   output logic xram_write_out,
   output logic [15:0] xwrite_addr_out
);
   pfs_stack_if st ();
   pfs_pkg::pfs_state_type state_q;
   pfs_pkg::pfs_state_type state_d;
   pfs_pkg::pfs_kind_type kind;
   logic [15:0] pc_q;
   logic [15:0] pc_d;
   logic [7:0] op_q;
   logic [7:0] b1_q;
   logic [7:0] b2_q;
   logic [15:0] ret_q;
   logic [15:0] tgt_q;
   logic [15:0] len;
   logic irq_q;
   logic [7:0] acc_q;
   logic acc_ld_q;
   logic fw_q;
   logic fe_q;
   logic xw_q;
   logic [15:0] xa_q;

   pfs_decode u_dec (
      .opcode_in(op_q),
      .kind_out(kind),
      .len_out(len)
   );
   pfs_stack u_stk (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .st(st.stk)
   );

   // next address after the whole instruction
   wire [15:0] next_pc = ret_q;
   wire [7:0] rel_byte = (op_q == `PFS_OP_BIT_JUMP) ? b2_q : b1_q;
   wire [15:0] rel_tgt = next_pc + {{8{rel_byte[7]}}, rel_byte};
   wire [15:0] abs_tgt = (next_pc & `PFS_BLOCK_MASK) | {5'h00, op_q[7:5], b1_q};
   wire [15:0] long_tgt = {b1_q, b2_q};
   wire take_bit_jump = test_bit_in;
   wire [15:0] table_addr = (op_q == `PFS_OP_TABLE_PTR) ? data_pointer_in + {8'h00, acc_in}
                                                      : next_pc + {8'h00, acc_in};
   wire is_xwrite = (op_q == `PFS_OP_EXT_WRITE);
   wire to_flash = is_xwrite && code_flash_write_select_in && !flash_protect_in;
   wire need2 = (len == `PFS_LEN_THREE);
   wire need1 = (len != `PFS_LEN_ONE);

   assign st.push = ce_in && (state_q == pfs_pkg::PFS_PUSH_LO || state_q == pfs_pkg::PFS_PUSH_HI);
   assign st.pop = ce_in && (state_q == pfs_pkg::PFS_POP_HI || state_q == pfs_pkg::PFS_POP_LO);
   // push writes at sp+1 (pre-increment), pop reads at sp
   assign st.push_data = (state_q == pfs_pkg::PFS_PUSH_LO) ? ret_q[7:0] : ret_q[15:8];
   assign stack_addr_out = st.push ? st.sp + `PFS_SP_STEP : st.sp;
   assign stack_wdata_out = st.push_data;
   assign stack_we_out = st.push;
   assign code_addr_out = (state_q == pfs_pkg::PFS_TABLE) ? table_addr : pc_q;
   assign irq_ack_out = ce_in && state_q == pfs_pkg::PFS_FETCH && irq_req_in;
   assign pc_out = pc_q;
   assign opcode_out = op_q;
   assign acc_load_out = acc_ld_q;
   assign acc_data_out = acc_q;
   assign flash_write_out = fw_q;
   assign flash_erase_out = fe_q;
   assign xram_write_out = xw_q;
   assign xwrite_addr_out = xa_q;

   always_comb begin
      state_d = state_q;
      pc_d = pc_q;
      case (state_q)
         pfs_pkg::PFS_FETCH: begin
            if (irq_req_in) begin
               state_d = pfs_pkg::PFS_PUSH_LO;
            end else begin
               pc_d = pc_q + `PFS_LEN_ONE;
               state_d = pfs_pkg::PFS_OPND1;
            end
         end
         pfs_pkg::PFS_OPND1: begin
            if (need1) begin
               pc_d = pc_q + `PFS_LEN_ONE;
            end
            state_d = need2 ? pfs_pkg::PFS_OPND2 : pfs_pkg::PFS_EXEC;
         end
         pfs_pkg::PFS_OPND2: begin
            pc_d = pc_q + `PFS_LEN_ONE;
            state_d = pfs_pkg::PFS_EXEC;
         end
         pfs_pkg::PFS_EXEC: begin
            state_d = pfs_pkg::PFS_FETCH;
            case (kind)
               pfs_pkg::PFS_LONG_JUMP: pc_d = long_tgt;
               pfs_pkg::PFS_SHORT_JUMP: pc_d = rel_tgt;
               pfs_pkg::PFS_BLOCK_JUMP: pc_d = abs_tgt;
               pfs_pkg::PFS_BIT_JUMP: pc_d = take_bit_jump ? rel_tgt : next_pc;
               pfs_pkg::PFS_LONG_CALL: state_d = pfs_pkg::PFS_PUSH_LO;
               pfs_pkg::PFS_EXIT: state_d = pfs_pkg::PFS_POP_HI;
               pfs_pkg::PFS_TABLE_READ: state_d = pfs_pkg::PFS_TABLE;
               default: pc_d = next_pc;
            endcase
         end
         pfs_pkg::PFS_PUSH_LO: state_d = pfs_pkg::PFS_PUSH_HI;
         pfs_pkg::PFS_PUSH_HI: begin
            pc_d = irq_q ? irq_vector_in : long_tgt;
            state_d = pfs_pkg::PFS_FETCH;
         end
         pfs_pkg::PFS_POP_HI: state_d = pfs_pkg::PFS_POP_LO;
         pfs_pkg::PFS_POP_LO: begin
            pc_d = {tgt_q[15:8], stack_rdata_in};
            state_d = pfs_pkg::PFS_FETCH;
         end
         pfs_pkg::PFS_TABLE: state_d = pfs_pkg::PFS_FETCH;
         default: state_d = pfs_pkg::PFS_FETCH;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= pfs_pkg::PFS_FETCH;
         pc_q <= `PFS_PC_RESET;
      end else if (ce_in) begin
         state_q <= state_d;
         pc_q <= pc_d;
      end
   end

   // instruction bytes and return address capture
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         op_q <= 8'h00;
         b1_q <= 8'h00;
         b2_q <= 8'h00;
         ret_q <= 16'h0000;
         irq_q <= 1'b0;
      end else if (ce_in) begin
         if (state_q == pfs_pkg::PFS_FETCH) begin
            op_q <= irq_req_in ? 8'h00 : code_data_in;
            irq_q <= irq_req_in;
            ret_q <= irq_req_in ? pc_q : pc_q + `PFS_LEN_ONE;
         end
         if (state_q == pfs_pkg::PFS_OPND1 && need1) begin
            b1_q <= code_data_in;
            ret_q <= pc_q + `PFS_LEN_ONE;
         end
         if (state_q == pfs_pkg::PFS_OPND2) begin
            b2_q <= code_data_in;
            ret_q <= pc_q + `PFS_LEN_ONE;
         end
         if (state_q == pfs_pkg::PFS_EXEC) begin
            irq_q <= 1'b0;
         end
      end
   end

   // popped high byte held until low byte arrives
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tgt_q <= 16'h0000;
      end else if (ce_in && state_q == pfs_pkg::PFS_POP_HI) begin
         tgt_q <= {stack_rdata_in, 8'h00};
      end
   end

   // table read result and external write steering
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acc_q <= 8'h00;
         acc_ld_q <= 1'b0;
         fw_q <= 1'b0;
         fe_q <= 1'b0;
         xw_q <= 1'b0;
         xa_q <= 16'h0000;
      end else if (ce_in) begin
         acc_ld_q <= (state_q == pfs_pkg::PFS_TABLE);
         if (state_q == pfs_pkg::PFS_TABLE) begin
            acc_q <= code_data_in;
         end
         fw_q <= state_q == pfs_pkg::PFS_EXEC && to_flash && !page_erase_in;
         fe_q <= state_q == pfs_pkg::PFS_EXEC && to_flash && page_erase_in;
         xw_q <= state_q == pfs_pkg::PFS_EXEC && is_xwrite && !code_flash_write_select_in;
         if (state_q == pfs_pkg::PFS_EXEC && is_xwrite) begin
            xa_q <= data_pointer_in;
         end
      end
   end
endmodule : pfs_seq

// file: rtl/pfs_map.svh
/*
 program flow sequencer constants: opcodes, reset values, widths.
 assumes inclusion by the design modules.
*/
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH
`define PFS_PC_RESET 16'h0000
`define PFS_SP_RESET 8'h07
`define PFS_OP_LONG_JUMP 8'h02
`define PFS_OP_SHORT_JUMP 8'h80
`define PFS_OP_BIT_JUMP 8'h20
`define PFS_OP_LONG_CALL 8'h12
`define PFS_OP_SUB_EXIT 8'h22
`define PFS_OP_IRQ_EXIT 8'h32
`define PFS_OP_TABLE_PTR 8'h93
`define PFS_OP_TABLE_PC 8'h83
`define PFS_OP_EXT_WRITE 8'hF0
`define PFS_BLOCK_JUMP_MASK 8'h1F
`define PFS_BLOCK_JUMP_CODE 8'h01
`define PFS_BLOCK_MASK 16'hF800
`define PFS_LEN_ONE 16'h0001
`define PFS_LEN_TWO 16'h0002
`define PFS_LEN_THREE 16'h0003
`define PFS_SP_STEP 8'h01
`endif

// file: rtl/pfs_pkg.sv
/*
 program flow sequencer types.
 assumes pfs_map.svh for numeric constants.
*/
package pfs_pkg;
   typedef enum logic [2:0] {
      PFS_OTHER, PFS_LONG_JUMP, PFS_SHORT_JUMP, PFS_BLOCK_JUMP, PFS_BIT_JUMP, PFS_LONG_CALL, PFS_EXIT,
      PFS_TABLE_READ
   } pfs_kind_type;
   typedef enum logic [3:0] {
      PFS_FETCH, PFS_OPND1, PFS_OPND2, PFS_EXEC, PFS_PUSH_LO, PFS_PUSH_HI,
      PFS_POP_HI, PFS_POP_LO, PFS_TABLE
   } pfs_state_type;
endpackage : pfs_pkg

// file: rtl/pfs_stack_if.sv
/*
 carrier between sequencer and stack unit.
 assumes one clock domain.
*/
`timescale 1ns/1ps
interface pfs_stack_if;
   logic push;
   logic pop;
   logic [7:0] push_data;
   logic [7:0] sp;
   modport seq (output push, output pop, output push_data, input sp);
   modport stk (input push, input pop, input push_data, output sp);
endinterface : pfs_stack_if

// file: rtl/pfs_stack.sv
/*
 stack pointer unit: pre-increment push, post-decrement pop.
 assumes push and pop never asserted together.
*/
`timescale 1ns/1ps
`include "pfs_map.svh"
module pfs_stack (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // carrier
   pfs_stack_if.stk st
);
   logic [7:0] sp_q;
   logic [7:0] sp_d;
   assign sp_d = st.push ? sp_q + `PFS_SP_STEP : (st.pop ? sp_q - `PFS_SP_STEP : sp_q);
   assign st.sp = sp_q;
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sp_q <= `PFS_SP_RESET;
      end else if (ce_in) begin
         sp_q <= sp_d;
      end
   end
endmodule : pfs_stack

// file: rtl/pfs_decode.sv
/*
 opcode classifier and instruction length.
 assumes opcode is the first byte of a standard encoding.
*/
`timescale 1ns/1ps
`include "pfs_map.svh"
module pfs_decode (
   // opcode in
   input wire logic [7:0] opcode_in,
   // class out
   output pfs_pkg::pfs_kind_type kind_out,
   output logic [15:0] len_out
);
   wire is_block_jump = (opcode_in & `PFS_BLOCK_JUMP_MASK) == `PFS_BLOCK_JUMP_CODE;
   assign kind_out = (opcode_in == `PFS_OP_LONG_JUMP) ? pfs_pkg::PFS_LONG_JUMP :
                     (opcode_in == `PFS_OP_SHORT_JUMP) ? pfs_pkg::PFS_SHORT_JUMP :
                     is_block_jump ? pfs_pkg::PFS_BLOCK_JUMP :
                     (opcode_in == `PFS_OP_BIT_JUMP) ? pfs_pkg::PFS_BIT_JUMP :
                     (opcode_in == `PFS_OP_LONG_CALL) ? pfs_pkg::PFS_LONG_CALL :
                     (opcode_in == `PFS_OP_SUB_EXIT || opcode_in == `PFS_OP_IRQ_EXIT) ? pfs_pkg::PFS_EXIT :
                     (opcode_in == `PFS_OP_TABLE_PTR || opcode_in == `PFS_OP_TABLE_PC) ? pfs_pkg::PFS_TABLE_READ :
                     pfs_pkg::PFS_OTHER;
   assign len_out = (opcode_in == `PFS_OP_LONG_JUMP || opcode_in == `PFS_OP_LONG_CALL ||
                     opcode_in == `PFS_OP_BIT_JUMP) ? `PFS_LEN_THREE :
                    (opcode_in == `PFS_OP_SHORT_JUMP || is_block_jump) ? `PFS_LEN_TWO : `PFS_LEN_ONE;
endmodule : pfs_decode

// file: sim/pfs_code_mem.sv
/* code memory and stack ram seen by pfs_seq.
 assumes combinational reads and writes taken at the clock edge. */
`timescale 1ns/1ps
module pfs_code_mem (
   // clock
   input wire logic ref_clk_in,
   // code side
   input wire logic [15:0] code_addr_in,
   output logic [7:0] code_data_out,
   // stack side
   input wire logic [7:0] stack_addr_in,
   input wire logic [7:0] stack_wdata_in,
   input wire logic stack_we_in,
   output logic [7:0] stack_rdata_out
);
   logic [7:0] mem [0:65535];
   logic [7:0] ram [0:255];
   assign code_data_out = mem[code_addr_in];
   assign stack_rdata_out = ram[stack_addr_in];
   always @(posedge ref_clk_in) begin
      if (stack_we_in === 1'b1) begin
         ram[stack_addr_in] <= stack_wdata_in;
      end
   end
endmodule : pfs_code_mem

// file: sim/pfs_seq_checker.sv
/* concurrent checks on the pfs_seq ports.
 assumes one clock and an async active-low reset; bound below. */
`timescale 1ns/1ps
module pfs_seq_checker (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // watched ports
   input wire logic [15:0] code_addr_out,
   input wire logic [7:0] code_data_in,
   input wire logic [15:0] data_pointer_in,
   input wire logic code_flash_write_select_in,
   input wire logic flash_protect_in,
   input wire logic page_erase_in,
   input wire logic [15:0] irq_vector_in,
   input wire logic irq_ack_out,
   input wire logic [7:0] stack_addr_out,
   input wire logic [7:0] stack_wdata_out,
   input wire logic stack_we_out,
   input wire logic acc_load_out,
   input wire logic [7:0] acc_data_out,
   input wire logic flash_write_out,
   input wire logic flash_erase_out,
   input wire logic xram_write_out,
   input wire logic [15:0] xwrite_addr_out
);
   logic run_q;
   logic pushed_q;
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         run_q <= 1'b0;
         pushed_q <= 1'b0;
      end else begin
         run_q <= 1'b1;
         pushed_q <= pushed_q | stack_we_out;
      end
   end
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   a_reset_pc_zero: assert property (!run_q |-> code_addr_out == 16'h0000)
      else $error("first fetch not at zero");
   a_first_push: assert property (stack_we_out && !pushed_q |-> stack_addr_out == 8'h08)
      else $error("first push not at 08");
   a_push_pair: assert property ($rose(stack_we_out) |=>
      stack_we_out && stack_addr_out == $past(stack_addr_out) + 8'h01 ##1 !stack_we_out)
      else $error("push pair broken");
   a_irq_push: assert property (irq_ack_out |=>
      stack_we_out && stack_wdata_out == $past(code_addr_out[7:0]) ##1
      stack_we_out && stack_wdata_out == $past(code_addr_out[15:8], 2) ##1 code_addr_out == $past(irq_vector_in))
      else $error("interrupt entry wrong");
   a_flash_gate: assert property (flash_write_out || flash_erase_out |->
      $past(code_flash_write_select_in) && !$past(flash_protect_in) && flash_erase_out == $past(page_erase_in))
      else $error("flash pulse not allowed");
   a_xram_route: assert property (xram_write_out |-> !$past(code_flash_write_select_in))
      else $error("external write while flash selected");
   a_write_addr: assert property (flash_write_out || flash_erase_out || xram_write_out |->
      $onehot0({flash_write_out, flash_erase_out, xram_write_out}) && xwrite_addr_out == $past(data_pointer_in))
      else $error("write pulse address wrong");
   a_table_data: assert property (acc_load_out |-> acc_data_out == $past(code_data_in))
      else $error("table byte wrong");
endmodule : pfs_seq_checker
bind pfs_seq pfs_seq_checker u_chk (.ref_clk_in, .rst_n_in, .code_addr_out, .code_data_in, .data_pointer_in,
   .code_flash_write_select_in, .flash_protect_in, .page_erase_in, .irq_vector_in, .irq_ack_out,
   .stack_addr_out, .stack_wdata_out, .stack_we_out, .acc_load_out, .acc_data_out, .flash_write_out,
   .flash_erase_out, .xram_write_out, .xwrite_addr_out);

// file: sim/program_flow_sequencer_test.sv
/* random instruction stream written just ahead of each fetch, run against a flow model.
 assumes pfs_code_mem serves code and stack. */
`timescale 1ns/1ps
module program_flow_sequencer_test;
   logic ref_clk_in = 1'b0, rst_n_in = 1'b0, test_bit_in = 1'b0, irq_req_in = 1'b0;
   logic code_flash_write_select_in = 1'b0, flash_protect_in = 1'b0, page_erase_in = 1'b0;
   logic [7:0] acc_in = 8'h00, code_data_in, stack_addr_out, stack_wdata_out, stack_rdata_in, acc_data_out;
   logic [15:0] data_pointer_in = 16'h0000, irq_vector_in = 16'h0000, code_addr_out, xwrite_addr_out, pc_out;
   logic [7:0] opcode_out;
   logic irq_ack_out, stack_we_out, acc_load_out, flash_write_out, flash_erase_out, xram_write_out;
   int failures = 0, samples_checked = 0, cycles = 0, depth = 0;
   logic [15:0] pc = 16'h0000;
   logic [15:0] rets[$];
   logic [7:0] exp_acc[$], got_acc[$];
   logic [18:0] exp_wr[$], got_wr[$];
   pfs_seq u_dut (.ref_clk_in, .rst_n_in, .ce_in(1'b1), .code_addr_out, .code_data_in, .acc_in,
      .data_pointer_in, .test_bit_in, .code_flash_write_select_in, .flash_protect_in, .page_erase_in,
      .irq_req_in, .irq_vector_in, .irq_ack_out, .stack_addr_out, .stack_wdata_out, .stack_we_out,
      .stack_rdata_in, .pc_out, .opcode_out, .acc_load_out, .acc_data_out, .flash_write_out,
      .flash_erase_out, .xram_write_out, .xwrite_addr_out);
   pfs_code_mem u_mem (.ref_clk_in, .code_addr_in(code_addr_out), .code_data_out(code_data_in),
      .stack_addr_in(stack_addr_out), .stack_wdata_in(stack_wdata_out), .stack_we_in(stack_we_out),
      .stack_rdata_out(stack_rdata_in));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test();
      $display("compares %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test
   // boundary displacements come up often, not by luck
   function automatic logic [7:0] pick();
      return $urandom_range(0, 2) == 0 ? ($urandom_range(0, 1) ? 8'h80 : 8'h7F) : 8'($urandom);
   endfunction : pick
   function automatic logic [15:0] sx(input logic [7:0] r);
      return {{8{r[7]}}, r};
   endfunction : sx
   task automatic step();
      logic [7:0] op, b1, b2;
      logic [15:0] nxt;
      int k, cyc;
      k = $urandom_range(0, 10);
      b1 = pick();
      b2 = pick();
      acc_in = 8'($urandom);
      data_pointer_in = 16'($urandom);
      test_bit_in = 1'($urandom);
      code_flash_write_select_in = 1'($urandom);
      flash_protect_in = $urandom_range(0, 3) == 0;
      page_erase_in = 1'($urandom);
      irq_vector_in = 16'($urandom);
      irq_req_in = k == 10 && depth < 40;
      if (k == 5 && depth > 39 || k == 6 && depth == 0) k = 0;
      nxt = pc + 16'h0001;
      cyc = 3;
      op = 8'h00;
      case (k)
         1: begin op = 8'h02; nxt = {b1, b2}; cyc = 4; end
         2: begin op = 8'h80; nxt = pc + 16'h0002 + sx(b1); end
         3: begin op = {b2[2:0], 5'b00001}; nxt = ((pc + 16'h0002) & 16'hF800) | {5'h00, b2[2:0], b1}; end
         4: begin op = 8'h20; nxt = pc + 16'h0003 + (test_bit_in ? sx(b2) : 16'h0000); cyc = 4; end
         5: begin op = 8'h12; nxt = {b1, b2}; cyc = 6; rets.push_back(pc + 16'h0003); depth++; end
         6: begin op = b1[0] ? 8'h32 : 8'h22; nxt = rets.pop_back(); cyc = 5; depth--; end
         7: begin op = 8'h93; cyc = 4; end
         8: begin op = 8'h83; cyc = 4; end
         9: begin op = 8'hF0; end
         10: if (irq_req_in) begin nxt = irq_vector_in; rets.push_back(pc); depth++; end
         default: ;
      endcase
      u_mem.mem[pc] = op;
      u_mem.mem[pc + 16'h0001] = b1;
      u_mem.mem[pc + 16'h0002] = b2;
      if (k == 7) exp_acc.push_back(u_mem.mem[acc_in + data_pointer_in]);
      if (k == 8) exp_acc.push_back(u_mem.mem[acc_in + pc + 16'h0001]);
      if (k == 9 && !code_flash_write_select_in) exp_wr.push_back({3'b001, data_pointer_in});
      if (k == 9 && code_flash_write_select_in && !flash_protect_in)
         exp_wr.push_back({!page_erase_in, page_erase_in, 1'b0, data_pointer_in});
      #1;
      check(irq_ack_out, irq_req_in);
      check(code_addr_out, pc);
      check(pc_out, pc);
      repeat (cyc) @(posedge ref_clk_in);
      #1;
      check(opcode_out, op);
      pc = nxt;
   endtask : step
   initial begin
      forever #5 ref_clk_in = ~ref_clk_in;
   end
   always @(negedge ref_clk_in) begin
      if (acc_load_out === 1'b1) got_acc.push_back(acc_data_out);
      if ((flash_write_out | flash_erase_out | xram_write_out) === 1'b1)
         got_wr.push_back({flash_write_out, flash_erase_out, xram_write_out, xwrite_addr_out});
   end
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         stop_test();
      end
   end
   initial begin
      int s;
      s = $urandom(32'h7924);
      for (int i = 0; i < 65536; i++) u_mem.mem[i] = 8'($urandom);
      for (int i = 0; i < 256; i++) u_mem.ram[i] = 8'($urandom);
      repeat (10) @(posedge ref_clk_in);
      #1;
      rst_n_in = 1'b1;
      repeat (1500) step();
      // park on no-ops so stray memory bytes raise no late pulses
      for (int i = 0; i < 4; i++) u_mem.mem[pc + 16'(i)] = 8'h00;
      repeat (2) @(posedge ref_clk_in);
      check(got_acc.size(), exp_acc.size());
      check(got_wr.size(), exp_wr.size());
      foreach (exp_acc[i]) check(got_acc[i], exp_acc[i]);
      foreach (exp_wr[i]) check(got_wr[i], exp_wr[i]);
      stop_test();
   end
endmodule : program_flow_sequencer_test
